// file: timed_io_params.svh
`ifndef TIMED_IO_PARAMS_SVH
`define TIMED_IO_PARAMS_SVH

// Structure of the port bank.
`define NUM_PORTS    6
`define NUM_CLKBLK   6
`define PIN_COUNT    32
`define LINK_PIN_LO  28
`define LINK_PINS    4

// Register index map: port p occupies indices p*8 .. p*8+6.
`define ADDR_W       6
`define OFF_CTRL     3'h0
`define OFF_DATA     3'h1
`define OFF_TIME     3'h2
`define OFF_COUNT    3'h3
`define OFF_STAMP    3'h4
`define OFF_STAT     3'h5
`define OFF_COND     3'h6
`define CB_PAGE      3'h6
`define GLOBAL_ADDR  6'h38

// Port control register fields.
`define CTRL_W       10
`define CTRL_EN      0
`define CTRL_DIROUT  1
`define CTRL_OD      2
`define CTRL_CLK_LO  3
`define CTRL_CLK_HI  5
`define CTRL_CND_LO  6
`define CTRL_CND_HI  7
`define CTRL_SIN_EN  8
`define CTRL_SOUT_EN 9
`define CTRL_RESET   10'h000

// Status register fields.
`define STAT_TXFULL  0
`define STAT_RXFULL  1
`define STAT_ARMED   2

// Clock block configuration fields.
`define CB_SRC_PIN   0
`define CB_PIN_SEL   1
`define CB_DIV_LO    8
`define CB_DIV_HI    15
`define CB_RESET     16'h0000

// Global register fields.
`define GLB_LINK_EN  0

`define COUNT_RESET  16'h0000

`endif

// file: timed_io_pkg.sv
package timed_io_pkg;

	typedef enum logic [1:0] {
		COND_NONE,
		COND_EQUAL,
		COND_DIFFER,
		COND_RSVD
	} cond_mode_t;

	typedef logic [15:0] port_count_t;

endpackage : timed_io_pkg

// file: timed_io_port.sv
`timescale 1ns/100ps
`include "timed_io_params.svh"

module timed_io_port (
	// Clock and reset.
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// Register port.
	input  wire logic [`ADDR_W-1:0]  regAddr,
	input  wire logic [31:0]         regWrData,
	input  wire logic                regWr,
	input  wire logic                regRd,
	output logic      [31:0]         regRdData,
	// Pins.
	input  wire logic [31:0]         pinIn,
	output logic      [31:0]         pinOut,
	output logic      [31:0]         pinOe,
	// Strobes.
	input  wire logic                strobeIn,
	output logic                     strobeOut,
	// Link sharing pins 28 to 31.
	input  wire logic [3:0]          linkTx,
	output logic      [3:0]          linkRx,
	// Events to the processor.
	output logic      [5:0]          portEvent
);

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	function automatic logic [31:0] portMask(input logic [2:0] p);
		case (p)
			3'h0:    portMask = 32'h00000001;
			3'h1:    portMask = 32'h00000002;
			3'h2:    portMask = 32'h0000000F;
			3'h3:    portMask = 32'h000000FF;
			3'h4:    portMask = 32'h0000FFFF;
			3'h5:    portMask = 32'hFFFFFFFF;
			default: portMask = 32'h00000000;
		endcase
	endfunction : portMask

	function automatic logic [4:0] portBase(input logic [2:0] p);
		portBase = (p == 3'h1) ? 5'h01 : 5'h00;
	endfunction : portBase

	// Lowest-index port is the narrowest, so it is searched last and wins.
	function automatic logic [2:0] pinOwner(input logic [5:0] en,
			input logic [4:0] pin);
		logic [31:0] m;
		pinOwner = 3'h6;
		for (int p = 5; p >= 0; p--) begin
			m = portMask(3'(p));
			if (en[p] && m[pin])
				pinOwner = 3'(p);
		end
	endfunction : pinOwner

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [31:0] pinMeta_r;
	logic [31:0] pinSync_r;
	logic [31:0] pinPrev_r;
	logic        strobeMeta_r;
	logic        strobeSync_r;
	logic        linkEn_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pinMeta_r    <= 32'h00000000;
			pinSync_r    <= 32'h00000000;
			pinPrev_r    <= 32'h00000000;
			strobeMeta_r <= 1'b0;
			strobeSync_r <= 1'b0;
		end else begin
			pinMeta_r    <= pinIn;
			pinSync_r    <= pinMeta_r;
			pinPrev_r    <= pinSync_r;
			strobeMeta_r <= strobeIn;
			strobeSync_r <= strobeMeta_r;
		end
	end

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire [2:0]  selPort = regAddr[5:3];
	wire [2:0]  selOff  = regAddr[2:0];
	wire        cbHit   = (selPort == `CB_PAGE) && (selOff < 3'h6);
	wire        glbHit  = (regAddr == `GLOBAL_ADDR);

	// ----------------------------------------------------------------
	// Clock blocks
	// ----------------------------------------------------------------
	logic [15:0] cbCfg_r [`NUM_CLKBLK];
	logic [7:0]  cbCnt_r [`NUM_CLKBLK];
	wire  [5:0]  cbTick;

	assign cbCfg_r[0] = `CB_RESET;
	assign cbCnt_r[0] = 8'h00;
	assign cbTick[0]  = 1'b1;

	genvar c;
	generate
		for (c = 1; c < `NUM_CLKBLK; c++) begin : g_cb
			wire       selPin  = cbCfg_r[c][`CB_PIN_SEL];
			wire       pinEdge = pinSync_r[selPin] & ~pinPrev_r[selPin];
			wire       srcEdge = cbCfg_r[c][`CB_SRC_PIN] ? pinEdge : 1'b1;
			wire [7:0] divSet  = cbCfg_r[c][`CB_DIV_HI:`CB_DIV_LO];
			wire       divEnd  = (cbCnt_r[c] == divSet);
			assign cbTick[c] = srcEdge & divEnd;
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					cbCfg_r[c] <= `CB_RESET;
					cbCnt_r[c] <= 8'h00;
				end else begin
					if (regWr && cbHit && selOff == 3'(c))
						cbCfg_r[c] <= regWrData[15:0];
					if (srcEdge)
						cbCnt_r[c] <= divEnd ? 8'h00 : cbCnt_r[c] + 8'h01;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			linkEn_r <= 1'b0;
		else if (regWr && glbHit)
			linkEn_r <= regWrData[`GLB_LINK_EN];
	end

	// ----------------------------------------------------------------
	// Ports
	// ----------------------------------------------------------------
	logic [`CTRL_W-1:0] ctrl_r   [`NUM_PORTS];
	logic [31:0]        txXfer_r [`NUM_PORTS];
	logic [31:0]        pinReg_r [`NUM_PORTS];
	logic [31:0]        rxXfer_r [`NUM_PORTS];
	logic [31:0]        cond_r   [`NUM_PORTS];
	timed_io_pkg::port_count_t count_r  [`NUM_PORTS];
	timed_io_pkg::port_count_t target_r [`NUM_PORTS];
	timed_io_pkg::port_count_t stamp_r  [`NUM_PORTS];
	logic               txFull_r [`NUM_PORTS];
	logic               rxFull_r [`NUM_PORTS];
	logic               armed_r  [`NUM_PORTS];
	wire  [31:0]        portRd   [`NUM_PORTS];
	wire  [31:0]        portPinVal [`NUM_PORTS];
	wire  [5:0]         en;
	wire  [5:0]         dirOut;
	wire  [5:0]         odMode;
	wire  [5:0]         capture;
	wire  [5:0]         txMove;
	wire  [5:0]         portTick;

	genvar p;
	generate
		for (p = 0; p < `NUM_PORTS; p++) begin : g_port
			wire [2:0]  cbSel  = ctrl_r[p][`CTRL_CLK_HI:`CTRL_CLK_LO];
			wire [31:0] mask   = portMask(3'(p));
			wire [4:0]  base   = portBase(3'(p));
			// Taken-over pins are still sampled, keeping the full width.
			wire [31:0] pinData = (pinSync_r & mask) >> base;
			wire timed_io_pkg::cond_mode_t mode =
				timed_io_pkg::cond_mode_t'(ctrl_r[p][`CTRL_CND_HI:`CTRL_CND_LO]);
			wire        condOk = (mode == timed_io_pkg::COND_NONE) ||
				(mode == timed_io_pkg::COND_EQUAL  && pinData == cond_r[p]) ||
				(mode == timed_io_pkg::COND_DIFFER && pinData != cond_r[p]);
			wire        timeOk = !armed_r[p] || count_r[p] == target_r[p];
			wire        stbOk  = !ctrl_r[p][`CTRL_SIN_EN] || strobeSync_r;
			wire        hit    = regWr && selPort == 3'(p);
			wire        rdData = regRd && selPort == 3'(p) &&
				selOff == `OFF_DATA;

			assign en[p]       = ctrl_r[p][`CTRL_EN];
			assign dirOut[p]   = ctrl_r[p][`CTRL_DIROUT];
			assign odMode[p]   = ctrl_r[p][`CTRL_OD];
			assign portTick[p] = en[p] && cbSel < 3'h6 && cbTick[cbSel];
			assign capture[p]  = portTick[p] && !dirOut[p] && condOk &&
				timeOk && stbOk;
			assign txMove[p]   = portTick[p] && dirOut[p] && txFull_r[p] &&
				timeOk;
			assign portPinVal[p] = pinReg_r[p] << base;
			assign portRd[p] =
				(selOff == `OFF_CTRL)  ? {22'h000000, ctrl_r[p]} :
				(selOff == `OFF_DATA)  ? rxXfer_r[p] :
				(selOff == `OFF_TIME)  ? {16'h0000, target_r[p]} :
				(selOff == `OFF_COUNT) ? {16'h0000, count_r[p]} :
				(selOff == `OFF_STAMP) ? {16'h0000, stamp_r[p]} :
				(selOff == `OFF_STAT)  ? {29'h00000000, armed_r[p],
					rxFull_r[p], txFull_r[p]} :
				(selOff == `OFF_COND)  ? cond_r[p] : 32'h00000000;

			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					ctrl_r[p]   <= `CTRL_RESET;
					cond_r[p]   <= 32'h00000000;
					target_r[p] <= `COUNT_RESET;
					count_r[p]  <= `COUNT_RESET;
					stamp_r[p]  <= `COUNT_RESET;
					txXfer_r[p] <= 32'h00000000;
					pinReg_r[p] <= 32'h00000000;
					rxXfer_r[p] <= 32'h00000000;
					txFull_r[p] <= 1'b0;
					rxFull_r[p] <= 1'b0;
					armed_r[p]  <= 1'b0;
				end else begin
					if (hit && selOff == `OFF_CTRL)
						ctrl_r[p] <= regWrData[`CTRL_W-1:0];
					if (hit && selOff == `OFF_COND)
						cond_r[p] <= regWrData & (mask >> base);
					if (portTick[p])
						count_r[p] <= count_r[p] + 16'h0001;
					if (capture[p] || txMove[p])
						stamp_r[p] <= count_r[p];
					if (capture[p])
						rxXfer_r[p] <= pinData;
					if (txMove[p])
						pinReg_r[p] <= txXfer_r[p];
					if (hit && selOff == `OFF_DATA)
						txXfer_r[p] <= regWrData & (mask >> base);
					// A new event wins over a same-cycle clear.
					if (capture[p])
						rxFull_r[p] <= 1'b1;
					else if (rdData)
						rxFull_r[p] <= 1'b0;
					if (hit && selOff == `OFF_DATA)
						txFull_r[p] <= 1'b1;
					else if (txMove[p])
						txFull_r[p] <= 1'b0;
					if (hit && selOff == `OFF_TIME) begin
						target_r[p] <= regWrData[15:0];
						armed_r[p]  <= 1'b1;
					end else if (capture[p] || txMove[p]) begin
						armed_r[p]  <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin multiplexing
	// ----------------------------------------------------------------
	wire [31:0] pinOutNxt;
	wire [31:0] pinOeNxt;

	genvar i;
	generate
		for (i = 0; i < `PIN_COUNT; i++) begin : g_pin
			wire [2:0] own     = pinOwner(en, 5'(i));
			wire       linkPin = linkEn_r && i >= `LINK_PIN_LO;
			wire       drive   = own < 3'h6 && dirOut[own];
			wire       bitVal  = (own < 3'h6) ? portPinVal[own][i] : 1'b0;
			if (i >= `LINK_PIN_LO) begin : g_link
				assign pinOutNxt[i] = linkPin ? linkTx[i-`LINK_PIN_LO] :
					(drive && !odMode[own] && bitVal);
			end else begin : g_plain
				assign pinOutNxt[i] = drive && !odMode[own] && bitVal;
			end
			assign pinOeNxt[i] = linkPin ||
				(drive && (odMode[own] ? !bitVal : 1'b1));
		end
	endgenerate

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	wire [31:0] rdNxt = !regRd ? 32'h00000000 :
		(selPort < 3'h6) ? portRd[selPort] :
		cbHit ? {16'h0000, cbCfg_r[selOff]} :
		glbHit ? {31'h00000000, linkEn_r} : 32'h00000000;
	wire        stbNxt = |(txMove & {ctrl_r[5][`CTRL_SOUT_EN],
		ctrl_r[4][`CTRL_SOUT_EN], ctrl_r[3][`CTRL_SOUT_EN],
		ctrl_r[2][`CTRL_SOUT_EN], ctrl_r[1][`CTRL_SOUT_EN],
		ctrl_r[0][`CTRL_SOUT_EN]});
	// The move is held back one cycle so the strobe meets the new pin value.
	logic       stbMove_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stbMove_r <= 1'b0;
			regRdData <= 32'h00000000;
			pinOut    <= 32'h00000000;
			pinOe     <= 32'h00000000;
			strobeOut <= 1'b0;
			linkRx    <= 4'h0;
			portEvent <= 6'h00;
		end else begin
			regRdData <= rdNxt;
			pinOut    <= pinOutNxt;
			pinOe     <= pinOeNxt;
			stbMove_r <= stbNxt;
			strobeOut <= stbMove_r;
			linkRx    <= linkEn_r ? pinSync_r[31:28] : 4'h0;
			portEvent <= capture | txMove;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb_chk @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_reset_clk_zero: assert property (
		$fell(rst) |-> ctrl_r[3][`CTRL_CLK_HI:`CTRL_CLK_LO] == 3'h0)
		else $error("port not on clock block zero after reset");

	a_count_step: assert property (
		portTick[2] |=> count_r[2] == $past(count_r[2]) + 16'h0001)
		else $error("port counter did not step on its tick");

	a_stamp_latch: assert property (
		capture[4] |=> stamp_r[4] == $past(count_r[4]) && rxFull_r[4])
		else $error("timestamp not latched on capture");

	a_timed_wait: assert property (
		armed_r[0] && count_r[0] != target_r[0] |-> !capture[0] && !txMove[0])
		else $error("transfer before counter reached its target");

	a_link_owns: assert property (
		linkEn_r |=> pinOe[31:28] == 4'hF && pinOut[31:28] == $past(linkTx))
		else $error("link pins not handed to the link");

	a_od_low_only: assert property (
		!linkEn_r && en[2] && dirOut[2] && odMode[2]
		|=> !pinOut[2] && pinOe[2] == !$past(pinReg_r[2][2]))
		else $error("open-drain pin driven high");

	a_narrow_wins: assert property (
		en[2] && dirOut[2] && odMode[2] && en[3] && !en[0] && !en[1]
		&& !linkEn_r |=> pinOe[3:0] == ~$past(pinReg_r[2][3:0]))
		else $error("wider port overrode narrower port");

	a_read_count: assert property (
		regRd && regAddr == {3'h4, `OFF_COUNT}
		|=> regRdData == {16'h0000, $past(count_r[4])}
		##1 regRdData == 32'h0 || $past(regRd))
		else $error("counter read not answered next cycle");

	a_event_pulse: assert property (
		capture[4] |=> portEvent[4])
		else $error("capture did not raise a port event");

	c_capture: cover property (capture[4] ##1 portEvent[4]);
	c_timed_out: cover property (armed_r[0] ##[1:40] txMove[0]);
	c_link_on: cover property ($rose(linkEn_r));
	c_strobe_out: cover property (strobeOut);

endmodule : timed_io_port

// file: timed_io_pins_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Application hardware on the port pins
// ----------------------------------------------------------------
module timed_io_pins_model (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Device side of the pins.
	input  wire logic [31:0] pinOut,
	input  wire logic [31:0] pinOe,
	output logic      [31:0] pinIn,
	// Bench controls.
	input  wire logic [31:0] extData,
	input  wire logic        clkRun
);
	logic [2:0] phase_r;
	logic       extClk;

	// The external clock stands low whenever it is not running.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			phase_r <= 3'h0;
		else if (clkRun)
			phase_r <= phase_r + 3'h1;
		else
			phase_r <= 3'h0;
	end

	assign extClk = phase_r[2];

	// Pins the device drives show its level, the rest show the far side.
	always_comb begin
		pinIn = (pinOe & pinOut) | (~pinOe & extData);
		if (clkRun && !pinOe[1])
			pinIn[1] = extClk;
	end
endmodule : timed_io_pins_model

// file: timed_io_port_tb.sv
`timescale 1ns/100ps
`include "timed_io_params.svh"

module timed_io_port_tb;
	logic               clk_sys = 1'b0;
	logic               rst = 1'b1;
	logic [`ADDR_W-1:0] regAddr = '0;
	logic [31:0]        regWrData = '0;
	logic               regWr = 1'b0;
	logic               regRd = 1'b0;
	logic [31:0]        regRdData;
	logic [31:0]        pinIn;
	logic [31:0]        pinOut;
	logic [31:0]        pinOe;
	logic [31:0]        extData = '0;
	logic               strobeIn = 1'b0;
	logic               strobeOut;
	logic               clkRun = 1'b0;
	logic [3:0]         linkTx = 4'h0;
	logic [3:0]         linkRx;
	logic [5:0]         portEvent;
	logic [31:0]        rdv;
	logic [31:0]        c0;
	int                 errors = 0;
	int                 comparisons = 0;
	int                 cycles = 0;
	int                 strobes = 0;
	int                 events = 0;
	int                 s0;
	int                 e0;

	always #12.5 clk_sys = ~clk_sys;

	timed_io_port u_dut (
		.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .strobeIn(strobeIn), .strobeOut(strobeOut),
		.linkTx(linkTx), .linkRx(linkRx), .portEvent(portEvent)
	);

	timed_io_pins_model u_pins (
		.clk_sys(clk_sys), .rst(rst), .pinOut(pinOut), .pinOe(pinOe),
		.pinIn(pinIn), .extData(extData), .clkRun(clkRun)
	);

	// ----------------------------------------------------------------
	// Monitors and helpers
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		cycles++;
		if (strobeOut === 1'b1)
			strobes++;
		if (portEvent[0] === 1'b1)
			events++;
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		tick(1);
	endtask : wr

	task automatic rd(input logic [5:0] a);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 rdv = regRdData;
		tick(1);
	endtask : rd

	task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
		rd(a);
		chk(rdv, exp);
	endtask : rdchk

	task automatic quiet();
		for (int p = 0; p < 6; p++)
			wr(6'(p * 8), 32'h0);
	endtask : quiet

	// Disables port 4, empties its receive side and enables it again.
	task automatic arm(input logic [31:0] ctrl);
		wr(6'h20, 32'h0);
		rd(6'h21);
		wr(6'h20, ctrl);
	endtask : arm

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		tick(1);
		rdchk(6'h00, 32'h0);
		rdchk(6'h23, 32'h0);
		rdchk(6'h07, 32'h0);
		wr(6'h30, 32'hFFFF);
		rdchk(6'h30, 32'h0);
		s0 = strobes;
		e0 = events;
		wr(6'h00, 32'h203);
		wr(6'h01, 32'h1);
		tick(6);
		chk(32'(pinOut[0] & pinOe[0]), 32'h1);
		chk(32'(strobes - s0), 32'h1);
		chk(32'(events - e0), 32'h1);
		rdchk(6'h05, 32'h0);
		quiet();
		wr(6'h10, 32'h7);
		wr(6'h11, 32'hF5);
		tick(6);
		chk(32'(pinOe[7:0]), 32'h0A);
		chk(32'(pinOut[3:0]), 32'h0);
		wr(6'h18, 32'h3);
		wr(6'h19, 32'hFF);
		tick(6);
		chk(32'({pinOe[7:0], pinOut[7:0]}), 32'hFAF0);
		quiet();
		wr(6'h28, 32'h3);
		wr(6'h29, 32'hFFFFFFFF);
		wr(6'h38, 32'h1);
		linkTx <= 4'h5;
		tick(8);
		chk(pinOut, 32'h5FFFFFFF);
		chk(32'(linkRx), 32'h5);
		wr(6'h38, 32'h0);
		tick(6);
		chk(pinOut, 32'hFFFFFFFF);
		quiet();
		extData <= 32'hBEEF;
		wr(6'h20, 32'h1);
		tick(6);
		rdchk(6'h21, 32'hBEEF);
		rd(6'h23);
		c0 = rdv;
		tick(8);
		rdchk(6'h23, c0 + 32'd10);
		wr(6'h26, 32'h1234);
		extData <= 32'h0;
		arm(32'h41);
		tick(10);
		rdchk(6'h25, 32'h0);
		extData <= 32'h1234;
		tick(6);
		rdchk(6'h21, 32'h1234);
		arm(32'h101);
		tick(10);
		rdchk(6'h25, 32'h0);
		strobeIn <= 1'b1;
		tick(6);
		rdchk(6'h25, 32'h2);
		strobeIn <= 1'b0;
		quiet();
		rd(6'h03);
		c0 = rdv;
		wr(6'h02, c0 + 32'd20);
		wr(6'h01, 32'h1);
		wr(6'h00, 32'h3);
		tick(6);
		rdchk(6'h05, 32'h5);
		tick(20);
		rdchk(6'h04, c0 + 32'd20);
		rdchk(6'h05, 32'h0);
		quiet();
		wr(6'h31, 32'h0103);
		wr(6'h20, 32'h9);
		rd(6'h23);
		c0 = rdv;
		clkRun <= 1'b1;
		tick(64);
		clkRun <= 1'b0;
		tick(10);
		rdchk(6'h23, c0 + 32'd4);
		complete_run();
	end
endmodule : timed_io_port_tb
